// ===== hdl/clk_lp_cfg.svh
// register map, reset values, msi range and bus limits, fail timeout and timing counts
`ifndef CLK_LP_CFG_SVH
`define CLK_LP_CFG_SVH
`define OFS_CLKCFG 12'h000
`define OFS_GATES 12'h004
`define OFS_TRIM 12'h008
`define OFS_PWRCTL 12'h00c
`define OFS_STATUS 12'h010
`define OFS_RESETSTAT 12'h014
`define RST_CLKCFG 32'h0000_0500
`define RST_GATES 32'h0000_0001
`define RST_TRIM 32'h0000_1010
`define RST_PWRCTL 32'h0000_0000
`define STOP_WAKE_NS 8000
`define STBY_WAKE_NS 60000
`define CLK_PERIOD_NS 8
`define STOP_WAKE_CYC (`STOP_WAKE_NS / `CLK_PERIOD_NS)
`define STBY_WAKE_CYC (`STBY_WAKE_NS / `CLK_PERIOD_NS)
`define MSI_RANGE_2MHZ 3'h5
`define MSI_RANGE_MAX 3'h6
`define FAIL_TIMEOUT 8'h40
`define BUS_MAX_HZ 32000000
`define PLL_USB_HZ 48000000
`endif

// ===== hdl/clk_lp_pkg.sv
// types for the clock and low-power controller
package clk_lp_pkg;
    typedef enum logic [1:0] {SRC_MSI, SRC_HSI, SRC_HSE, SRC_PLL} sysSrc_t;
    typedef enum logic [1:0] {AUX_NONE, AUX_LSI, AUX_LSE, AUX_HSE} auxSrc_t;
    typedef enum {PM_RUN, PM_STOP, PM_STBY, PM_WAKE} pwrMode_t;
    typedef struct packed {
        logic [15:0] extLine;
        logic supplyLevel;
        logic comp1;
        logic comp2;
        logic usbWake;
    } stopWake_t;
    typedef struct packed {
        logic [2:0] wakePin;
        logic rtcEvent;
        logic wdgReset;
    } stbyWake_t;
    typedef struct packed {
        logic oscHse;
        logic oscHsi;
        logic oscMsi;
        logic oscLse;
        logic oscLsi;
        logic pllOn;
        logic regLowPower;
        logic coreOff;
    } pwrOut_t;
endpackage

// ===== hdl/clock_lp_ctrl.sv
// clock source selection, dividers, gating, fail monitor and low-power sequencing
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "clk_lp_cfg.svh"

module clock_lp_ctrl #(
    parameter int SYS_HZ = 32000000,
    parameter int NUM_GATES = 16,
    parameter int STOP_WAKE_CYCLES = `STOP_WAKE_CYC,
    parameter int STBY_WAKE_CYCLES = `STBY_WAKE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] oscReady,
    input wire logic hseAlive,
    input wire logic lsiTick,
    input wire logic refIntOn,
    input wire clk_lp_pkg::stopWake_t stopWake,
    input wire clk_lp_pkg::stbyWake_t stbyWake,
    input wire logic extResetPin,
    output clk_lp_pkg::pwrOut_t pwrOut,
    output logic [1:0] sysSrcSel,
    output logic [2:0] msiRange,
    output logic [7:0] hsiTrim,
    output logic [7:0] msiTrim,
    output logic [1:0] auxSrcSel,
    output logic usbClkEn,
    output logic coreClkEn,
    output logic ahbClkEn,
    output logic apb1ClkEn,
    output logic apb2ClkEn,
    output logic [NUM_GATES-1:0] periphClkEn,
    output logic memClkEn,
    output logic [1:0] clkOutSel,
    output logic failIrq,
    output logic stateLost
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SW = 5 + 1 + 1 + 1 + $bits(clk_lp_pkg::stopWake_t) + $bits(clk_lp_pkg::stbyWake_t) + 1;
    logic [SW-1:0] syncA_ff;
    logic [SW-1:0] syncB_ff;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
        end else begin
            syncA_ff <= {oscReady, hseAlive, lsiTick, refIntOn, stopWake, stbyWake, extResetPin};
            syncB_ff <= syncA_ff;
        end
    end
    logic [4:0] rdy;
    logic hseAliveS, lsiTickS, refOnS, extRstS;
    clk_lp_pkg::stopWake_t swS;
    clk_lp_pkg::stbyWake_t sbS;
    assign {rdy, hseAliveS, lsiTickS, refOnS, swS, sbS, extRstS} = syncB_ff;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // clkcfg: [1:0] src req, [4:2] ahb div, [7:5] apb1 div, [10:8] msi range,
    // [12:11] aux src, [14:13] clkout sel, [15] fail mon en, [16] fail irq en,
    // [19:17] apb2 div
    logic [31:0] clkCfg_ff;
    logic [31:0] gates_ff;
    logic [31:0] trim_ff;
    logic [31:0] pwrCtl_ff;
    logic [1:0] srcAct_ff;
    logic failFlag_ff;
    logic [15:0] lsiCnt_ff;
    logic [15:0] lsiMeas_ff;
    logic [2:0] rstCause_ff;
    clk_lp_pkg::pwrMode_t mode_ff;

    logic wr, rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // safe divider limit: ahb and apb must stay at or below bus maximum
    function automatic logic [2:0] limitDiv(input logic [2:0] d);
        if ((SYS_HZ >> d) > `BUS_MAX_HZ)
            limitDiv = 3'h1;
        else
            limitDiv = d;
    endfunction

    logic clkCfgWrite;
    assign clkCfgWrite = wr && paddr == `OFS_CLKCFG;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clkCfg_ff <= `RST_CLKCFG;
            gates_ff <= `RST_GATES;
            trim_ff <= `RST_TRIM;
            pwrCtl_ff <= `RST_PWRCTL;
        end else if (mode_ff == clk_lp_pkg::PM_WAKE && pwrCtl_ff[1]) begin
            // standby exit behaves as a reset of ordinary state
            clkCfg_ff <= `RST_CLKCFG;
            gates_ff <= `RST_GATES;
            trim_ff <= `RST_TRIM;
            pwrCtl_ff <= `RST_PWRCTL;
        end else if (wr) begin
            unique case (paddr)
                `OFS_CLKCFG: begin
                    clkCfg_ff <= pwdata;
                    clkCfg_ff[4:2] <= limitDiv(pwdata[4:2]);
                    if (pwdata[10:8] > `MSI_RANGE_MAX)
                        clkCfg_ff[10:8] <= `MSI_RANGE_MAX;
                end
                `OFS_GATES: gates_ff <= pwdata;
                `OFS_TRIM: trim_ff <= pwdata;
                `OFS_PWRCTL: pwrCtl_ff <= pwdata;
                default: ;
            endcase
        end else if (mode_ff != clk_lp_pkg::PM_RUN) begin
            pwrCtl_ff[0] <= 1'b0; // entry request consumed
        end
    end

    // ------------------------------------------------------------
    // source switching and fail monitor
    // ------------------------------------------------------------
    logic [7:0] failCnt_ff;
    logic failDet;
    assign failDet = clkCfg_ff[15] && failCnt_ff == `FAIL_TIMEOUT;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            failCnt_ff <= 8'h00;
        end else if (hseAliveS || !clkCfg_ff[15]) begin
            failCnt_ff <= 8'h00;
        end else if (failCnt_ff != `FAIL_TIMEOUT) begin
            failCnt_ff <= failCnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            srcAct_ff <= 2'(clk_lp_pkg::SRC_MSI);
        end else if (failDet && srcAct_ff inside {2'(clk_lp_pkg::SRC_HSE), 2'(clk_lp_pkg::SRC_PLL)}) begin
            srcAct_ff <= 2'(clk_lp_pkg::SRC_HSI);
        end else if (mode_ff == clk_lp_pkg::PM_WAKE) begin
            srcAct_ff <= 2'(clk_lp_pkg::SRC_MSI);
        end else if (clkCfg_ff[1:0] != srcAct_ff && rdy[clkCfg_ff[1:0]]
            && !(failFlag_ff && clkCfg_ff[1])) begin
            // a failed crystal must not be reselected until software clears the flag
            srcAct_ff <= clkCfg_ff[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            failFlag_ff <= 1'b0;
        end else if (failDet) begin
            failFlag_ff <= 1'b1;
        end else if (wr && paddr == `OFS_STATUS && pwdata[0]) begin
            failFlag_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // slow oscillator measurement against fast internal
    // ------------------------------------------------------------
    logic lsiTickD_ff;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lsiTickD_ff <= 1'b0;
            lsiCnt_ff <= 16'h0000;
            lsiMeas_ff <= 16'h0000;
        end else begin
            lsiTickD_ff <= lsiTickS;
            if (lsiTickS && !lsiTickD_ff) begin
                lsiMeas_ff <= lsiCnt_ff;
                lsiCnt_ff <= 16'h0000;
            end else if (lsiCnt_ff != 16'hffff) begin
                lsiCnt_ff <= lsiCnt_ff + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // divider enables applied on period boundaries
    // ------------------------------------------------------------
    logic [6:0] divCnt_ff;
    logic [2:0] ahbDiv_ff, apb1Div_ff, apb2Div_ff;
    logic ahbTick, apb1Tick, apb2Tick;
    assign ahbTick = (divCnt_ff & ((7'h01 << ahbDiv_ff) - 7'h01)) == 7'h00;
    assign apb1Tick = ahbTick && (divCnt_ff & ((7'h01 << (ahbDiv_ff + apb1Div_ff)) - 7'h01)) == 7'h00;
    assign apb2Tick = ahbTick && (divCnt_ff & ((7'h01 << (ahbDiv_ff + apb2Div_ff)) - 7'h01)) == 7'h00;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divCnt_ff <= 7'h00;
            ahbDiv_ff <= 3'h0;
            apb1Div_ff <= 3'h0;
            apb2Div_ff <= 3'h0;
        end else begin
            divCnt_ff <= divCnt_ff + 7'h01;
            if (divCnt_ff == 7'h7f) begin
                ahbDiv_ff <= clkCfg_ff[4:2];
                apb1Div_ff <= clkCfg_ff[7:5] > 3'h4 ? 3'h4 : clkCfg_ff[7:5];
                apb2Div_ff <= clkCfg_ff[19:17] > 3'h4 ? 3'h4 : clkCfg_ff[19:17];
            end
        end
    end

    // ------------------------------------------------------------
    // power mode sequencing
    // ------------------------------------------------------------
    logic [13:0] wakeCnt_ff;
    logic stopEv, stbyEv;
    assign stopEv = |swS.extLine || swS.supplyLevel || swS.comp1 || (swS.comp2 && refOnS)
        || swS.usbWake;
    logic [2:0] pinD_ff;
    assign stbyEv = extRstS || |(sbS.wakePin & ~pinD_ff)
        || (pwrCtl_ff[2] && (sbS.rtcEvent || sbS.wdgReset));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_ff <= clk_lp_pkg::PM_RUN;
            wakeCnt_ff <= 14'h0000;
            pinD_ff <= 3'h0;
            rstCause_ff <= 3'h0;
        end else begin
            pinD_ff <= sbS.wakePin;
            unique case (mode_ff)
                clk_lp_pkg::PM_RUN: begin
                    if (pwrCtl_ff[0])
                        mode_ff <= pwrCtl_ff[1] ? clk_lp_pkg::PM_STBY : clk_lp_pkg::PM_STOP;
                end
                clk_lp_pkg::PM_STOP: begin
                    if (stopEv) begin
                        mode_ff <= clk_lp_pkg::PM_WAKE;
                        wakeCnt_ff <= 14'(STOP_WAKE_CYCLES - 1);
                    end
                end
                clk_lp_pkg::PM_STBY: begin
                    if (stbyEv) begin
                        mode_ff <= clk_lp_pkg::PM_WAKE;
                        wakeCnt_ff <= 14'(STBY_WAKE_CYCLES - 1);
                        rstCause_ff <= {extRstS, sbS.wdgReset, |sbS.wakePin};
                    end
                end
                clk_lp_pkg::PM_WAKE: begin
                    if (wakeCnt_ff == 14'h0000)
                        mode_ff <= clk_lp_pkg::PM_RUN;
                    else
                        wakeCnt_ff <= wakeCnt_ff - 14'h0001;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic inLp;
    assign inLp = mode_ff == clk_lp_pkg::PM_STOP || mode_ff == clk_lp_pkg::PM_STBY;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwrOut <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            sysSrcSel <= 2'(clk_lp_pkg::SRC_MSI);
            msiRange <= `MSI_RANGE_2MHZ;
            hsiTrim <= 8'h10;
            msiTrim <= 8'h10;
            auxSrcSel <= 2'(clk_lp_pkg::AUX_NONE);
            usbClkEn <= 1'b0;
            coreClkEn <= 1'b1;
            ahbClkEn <= 1'b0;
            apb1ClkEn <= 1'b0;
            apb2ClkEn <= 1'b0;
            periphClkEn <= '0;
            memClkEn <= 1'b0;
            clkOutSel <= 2'h0;
            failIrq <= 1'b0;
            stateLost <= 1'b0;
        end else begin
            pwrOut.oscHse <= !inLp && (srcAct_ff == 2'(clk_lp_pkg::SRC_HSE) || clkCfg_ff[1:0] == 2'(clk_lp_pkg::SRC_HSE)
                || clkCfg_ff[1:0] == 2'(clk_lp_pkg::SRC_PLL));
            pwrOut.oscHsi <= !inLp && (srcAct_ff == 2'(clk_lp_pkg::SRC_HSI) || failFlag_ff);
            pwrOut.oscMsi <= !inLp;
            // slow sources stay up in low power unless standby without rtc
            pwrOut.oscLse <= clkCfg_ff[12:11] == 2'(clk_lp_pkg::AUX_LSE) && !(mode_ff == clk_lp_pkg::PM_STBY
                && !pwrCtl_ff[2]);
            pwrOut.oscLsi <= !(mode_ff == clk_lp_pkg::PM_STBY && !pwrCtl_ff[2]);
            pwrOut.pllOn <= !inLp && (clkCfg_ff[1:0] == 2'(clk_lp_pkg::SRC_PLL) || gates_ff[20]);
            pwrOut.regLowPower <= mode_ff == clk_lp_pkg::PM_STOP;
            pwrOut.coreOff <= mode_ff == clk_lp_pkg::PM_STBY;
            sysSrcSel <= srcAct_ff;
            msiRange <= clkCfg_ff[10:8];
            hsiTrim <= trim_ff[7:0];
            msiTrim <= trim_ff[15:8];
            auxSrcSel <= clkCfg_ff[12:11];
            usbClkEn <= !inLp && gates_ff[20] && rdy[3];
            coreClkEn <= !inLp && gates_ff[0];
            ahbClkEn <= !inLp && ahbTick;
            apb1ClkEn <= !inLp && apb1Tick;
            apb2ClkEn <= !inLp && apb2Tick;
            periphClkEn <= inLp ? '0 : NUM_GATES'(gates_ff[NUM_GATES+1:2]);
            memClkEn <= !inLp && gates_ff[1];
            clkOutSel <= clkCfg_ff[14:13];
            failIrq <= failFlag_ff && clkCfg_ff[16];
            stateLost <= mode_ff == clk_lp_pkg::PM_STBY;
        end
    end

    // ------------------------------------------------------------
    // apb slave: zero wait states, unmapped reads zero, error only above the resetstat offset
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > `OFS_RESETSTAT;
            if (rd) begin
                unique case (paddr)
                    `OFS_CLKCFG: prdata <= clkCfg_ff;
                    `OFS_GATES: prdata <= gates_ff;
                    `OFS_TRIM: prdata <= trim_ff;
                    `OFS_PWRCTL: prdata <= pwrCtl_ff;
                    `OFS_STATUS: prdata <= {lsiMeas_ff, 8'h00, rdy, srcAct_ff, failFlag_ff};
                    `OFS_RESETSTAT: prdata <= {29'h0000_0000, rstCause_ff};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ===== tb/clock_lp_ctrl_props.sv
// port-level checks of the clock and low-power controller
`timescale 1ns/1ps

module clock_lp_ctrl_props #(
    parameter int STOP_WAKE_CYCLES = 4,
    parameter int STBY_WAKE_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] oscReady,
    input wire logic refIntOn,
    input wire clk_lp_pkg::stopWake_t stopWake,
    input wire clk_lp_pkg::stbyWake_t stbyWake,
    input wire clk_lp_pkg::pwrOut_t pwrOut,
    input wire logic [1:0] sysSrcSel,
    input wire logic [2:0] msiRange,
    input wire logic coreClkEn,
    input wire logic memClkEn,
    input wire logic failIrq
);
    // margin covers the two sync stages and the registered outputs
    localparam int STOP_LIM = STOP_WAKE_CYCLES + 8;
    localparam int STBY_LIM = STBY_WAKE_CYCLES + 8;
    default clocking cbMain @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_rst_default;
        $fell(rst) |-> sysSrcSel == 2'h0 && msiRange == 3'h5 && coreClkEn;
    endproperty
    a_rst_default: assert property (p_rst_default) else $error("wrong clock defaults after reset");
    property p_stop_off;
        pwrOut.regLowPower && !pwrOut.coreOff |-> !(pwrOut.oscHse || pwrOut.oscHsi || pwrOut.oscMsi
            || pwrOut.pllOn || coreClkEn || memClkEn);
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("clock running in deep stop");
    property p_stby_off;
        pwrOut.coreOff |-> !(pwrOut.oscHse || pwrOut.oscHsi || pwrOut.oscMsi || pwrOut.pllOn);
    endproperty
    a_stby_off: assert property (p_stby_off) else $error("fast oscillator on in standby");
    property p_src_ready;
        $changed(sysSrcSel) && sysSrcSel[1] |-> |($past(oscReady, 3) & (5'h01 << sysSrcSel));
    endproperty
    a_src_ready: assert property (p_src_ready) else $error("switched to a source not ready");
    property p_fail_hsi;
        $rose(failIrq) |-> ##[0:2] sysSrcSel == 2'h1;
    endproperty
    a_fail_hsi: assert property (p_fail_hsi) else $error("fail flag without fallback");
    property p_stop_wake;
        pwrOut.regLowPower && !pwrOut.coreOff && (|stopWake.extLine || stopWake.comp1)
            |-> ##[1:STOP_LIM] !pwrOut.regLowPower;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("deep stop exit too slow");
    property p_cmp2_ref;
        (pwrOut.regLowPower && stopWake == 20'h00002 && !refIntOn) [*4] |=> pwrOut.regLowPower;
    endproperty
    a_cmp2_ref: assert property (p_cmp2_ref) else $error("comparator 2 woke without reference");
    property p_stby_wake;
        pwrOut.coreOff && $rose(|stbyWake.wakePin) |-> ##[1:STBY_LIM] !pwrOut.coreOff;
    endproperty
    a_stby_wake: assert property (p_stby_wake) else $error("standby exit too slow");
endmodule

bind clock_lp_ctrl clock_lp_ctrl_props #(
    .STOP_WAKE_CYCLES(STOP_WAKE_CYCLES),
    .STBY_WAKE_CYCLES(STBY_WAKE_CYCLES)
) i_props (
    .clk_sys(clk_sys), .rst(rst), .oscReady(oscReady), .refIntOn(refIntOn), .stopWake(stopWake),
    .stbyWake(stbyWake), .pwrOut(pwrOut), .sysSrcSel(sysSrcSel), .msiRange(msiRange),
    .coreClkEn(coreClkEn), .memClkEn(memClkEn), .failIrq(failIrq)
);

// ===== tb/osc_model.sv
// behavioural oscillator bank driven by the power outputs
`timescale 1ns/1ps

module osc_model (
    input wire logic clk_sys,
    input wire clk_lp_pkg::pwrOut_t pwrOut,
    input wire logic slow,
    input wire logic hseDead,
    output logic [4:0] oscReady,
    output logic hseAlive,
    output logic lsiTick
);
    logic [4:0] oscOn;
    logic [5:0] settle [5];
    logic [2:0] lsiDiv;
    assign oscOn = {pwrOut.oscLse, pwrOut.pllOn, pwrOut.oscHse, pwrOut.oscHsi, pwrOut.oscMsi};
    initial begin
        oscReady = 5'h00;
        hseAlive = 1'b0;
        lsiTick = 1'b0;
        lsiDiv = 3'h0;
        settle = '{default: 6'h00};
    end
    always @(posedge clk_sys) begin
        for (int i = 0; i < 5; i++) begin
            // ready drops at once when switched off, rises only after start-up
            settle[i] <= oscOn[i] ? settle[i] + 6'(settle[i] != 6'h3f) : 6'h00;
            oscReady[i] <= oscOn[i] && settle[i] >= (slow ? 6'h28 : 6'h03);
        end
        // a dead crystal stops toggling, the only thing the monitor can see
        hseAlive <= pwrOut.oscHse && !hseDead && !hseAlive;
        lsiDiv <= pwrOut.oscLsi ? lsiDiv + 3'h1 : 3'h0;
        lsiTick <= pwrOut.oscLsi && lsiDiv[2];
    end
endmodule

// ===== tb/clock_and_low_power_mode_ctrl_test.sv
// self-checking bench for the clock and low-power controller
`timescale 1ns/1ps
`include "clk_lp_cfg.svh"
`define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s expected %h seen %h", nm, e, g); end end

module clock_and_low_power_mode_ctrl_test;
    localparam int STOP_CYC = 4;
    localparam int STBY_CYC = 4;
    logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, lastErr, hseAlive, lsiTick, refIntOn = 1'b0, extResetPin = 1'b0;
    logic slow = 1'b0, hseDead = 1'b0, usbClkEn, coreClkEn, ahbClkEn, memClkEn, failIrq, stateLost;
    logic [4:0] oscReady;
    logic [1:0] sysSrcSel, auxSrcSel, clkOutSel;
    logic [2:0] msiRange;
    logic [7:0] hsiTrim, msiTrim;
    logic [15:0] periphClkEn;
    clk_lp_pkg::stopWake_t stopWake = '0;
    clk_lp_pkg::stbyWake_t stbyWake = '0;
    clk_lp_pkg::pwrOut_t pwrOut;
    clk_lp_pkg::stopWake_t sw [6] = '{20'h80000, 20'h00010, 20'h00008, 20'h00004, 20'h00002, 20'h00001};
    clk_lp_pkg::stbyWake_t bw [3] = '{5'h01, 5'h02, 5'h04};
    int n_fail = 0, checked = 0, n, cnt;

    clock_lp_ctrl #(.STOP_WAKE_CYCLES(STOP_CYC), .STBY_WAKE_CYCLES(STBY_CYC)) i_clock_lp_ctrl (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscReady(oscReady),
        .hseAlive(hseAlive), .lsiTick(lsiTick), .refIntOn(refIntOn), .stopWake(stopWake), .stbyWake(stbyWake),
        .extResetPin(extResetPin), .pwrOut(pwrOut), .sysSrcSel(sysSrcSel), .msiRange(msiRange),
        .hsiTrim(hsiTrim), .msiTrim(msiTrim), .auxSrcSel(auxSrcSel), .usbClkEn(usbClkEn), .coreClkEn(coreClkEn),
        .ahbClkEn(ahbClkEn), .apb1ClkEn(), .apb2ClkEn(), .periphClkEn(periphClkEn), .memClkEn(memClkEn),
        .clkOutSel(clkOutSel), .failIrq(failIrq), .stateLost(stateLost)
    );
    osc_model i_osc (.clk_sys(clk_sys), .pwrOut(pwrOut), .slow(slow), .hseDead(hseDead),
        .oscReady(oscReady), .hseAlive(hseAlive), .lsiTick(lsiTick));

    always #4 clk_sys = ~clk_sys;

    // --------
    // bus tasks
    // --------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && k < 16) begin
            k++;
            @(posedge clk_sys);
        end
        `CHECK("pready", 1'b1, pready)
        r = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0, q);
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic stop_test();
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end

    // --------
    // tests
    // --------
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        step(1);
        `CHECK("sysSrcSel", 2'h0, sysSrcSel)
        `CHECK("msiRange", `MSI_RANGE_2MHZ, msiRange)
        rd(`OFS_CLKCFG);
        `CHECK("clkcfg", `RST_CLKCFG, q)
        rd(`OFS_GATES);
        `CHECK("gates", `RST_GATES, q)
        rd(`OFS_TRIM);
        `CHECK("trim", `RST_TRIM, q)
        rd(12'h018);
        `CHECK("pslverr", 1'b1, lastErr)
        wr(`OFS_TRIM, 32'h0000_a55a);
        step(2);
        `CHECK("hsiTrim", 8'h5a, hsiTrim)
        `CHECK("msiTrim", 8'ha5, msiTrim)
        for (int i = 0; i < 7; i++) begin
            wr(`OFS_CLKCFG, 32'(i << 8) | 32'((i % 4) << 11) | 32'(((i + 1) % 4) << 13));
            step(2);
            `CHECK("msiRange", 3'(i), msiRange)
            `CHECK("auxSrcSel", 2'(i % 4), auxSrcSel)
            `CHECK("clkOutSel", 2'((i + 1) % 4), clkOutSel)
        end
        for (int i = 0; i < 3; i++) begin
            q = (i == 0) ? 32'h0012_aaab : (i == 1) ? 32'h0000_5556 : 32'h0000_0003;
            wr(`OFS_GATES, q);
            step(20);
            `CHECK("coreClkEn", q[0], coreClkEn)
            `CHECK("memClkEn", q[1], memClkEn)
            `CHECK("periphClkEn", q[17:2], periphClkEn)
            `CHECK("usbClkEn", q[20], usbClkEn)
        end
        // divider takes the new ratio only when its count wraps
        for (int i = 1; i < 4; i += 2) begin
            wr(`OFS_CLKCFG, `RST_CLKCFG | 32'(i << 2));
            step(140);
            cnt = 0;
            repeat (64) begin
                @(negedge clk_sys);
                cnt += int'(ahbClkEn === 1'b1);
            end
            `CHECK("ahb pulses", 64 >> i, cnt)
        end
        @(posedge clk_sys);
        slow <= 1'b1;
        wr(`OFS_CLKCFG, `RST_CLKCFG | 32'h2);
        step(5);
        `CHECK("sysSrcSel", 2'h0, sysSrcSel)
        for (n = 0; n < 200 && sysSrcSel !== 2'h2; n++) @(negedge clk_sys);
        `CHECK("sysSrcSel", 2'h2, sysSrcSel)
        rd(`OFS_STATUS);
        `CHECK("status src", 2'h2, q[2:1])
        wr(`OFS_CLKCFG, `RST_CLKCFG | 32'h0001_8002);
        @(posedge clk_sys);
        hseDead <= 1'b1;
        for (n = 0; n < 300 && sysSrcSel !== 2'h1; n++) @(negedge clk_sys);
        step(2);
        `CHECK("sysSrcSel", 2'h1, sysSrcSel)
        `CHECK("failIrq", 1'b1, failIrq)
        wr(`OFS_CLKCFG, `RST_CLKCFG | 32'h1);
        @(posedge clk_sys);
        hseDead <= 1'b0;
        wr(`OFS_STATUS, 32'h1);
        step(2);
        `CHECK("failIrq", 1'b0, failIrq)
        wr(`OFS_PWRCTL, 32'h1);
        step(10);
        `CHECK("regLowPower", 1'b1, pwrOut.regLowPower)
        @(posedge clk_sys);
        stopWake <= 20'h00002;
        step(30);
        `CHECK("regLowPower", 1'b1, pwrOut.regLowPower)
        @(posedge clk_sys);
        stopWake <= '0;
        refIntOn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (i > 0) wr(`OFS_PWRCTL, 32'h1);
            step(10);
            @(posedge clk_sys);
            stopWake <= sw[i];
            for (n = 0; n < STOP_CYC + 12 && pwrOut.regLowPower !== 1'b0; n++) @(negedge clk_sys);
            `CHECK("stop exit", 1'b0, pwrOut.regLowPower)
            @(posedge clk_sys);
            stopWake <= '0;
            step(STOP_CYC + 10);
        end
        rd(`OFS_CLKCFG);
        `CHECK("clkcfg kept", `RST_CLKCFG | 32'h1, q)
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_PWRCTL, 32'h7);
            step(10);
            `CHECK("stateLost", 1'b1, stateLost)
            `CHECK("slow osc", 1'b1, pwrOut.oscLse | pwrOut.oscLsi)
            @(posedge clk_sys);
            stbyWake <= bw[i];
            for (n = 0; n < STBY_CYC + 12 && pwrOut.coreOff !== 1'b0; n++) @(negedge clk_sys);
            `CHECK("standby exit", 1'b0, pwrOut.coreOff)
            @(posedge clk_sys);
            stbyWake <= '0;
            step(STBY_CYC + 10);
            rd(`OFS_CLKCFG);
            `CHECK("clkcfg lost", `RST_CLKCFG, q)
        end
        for (int j = 0; j < 2; j++) begin
            wr(`OFS_PWRCTL, 32'h3);
            step(10);
            `CHECK("all osc", 5'h0, {pwrOut.oscHse, pwrOut.oscHsi, pwrOut.oscMsi, pwrOut.oscLse, pwrOut.oscLsi})
            @(posedge clk_sys);
            stbyWake <= 5'h02;
            step(40);
            `CHECK("coreOff", 1'b1, pwrOut.coreOff)
            @(posedge clk_sys);
            stbyWake <= (j == 0) ? 5'h10 : 5'h00;
            extResetPin <= (j == 1);
            for (n = 0; n < STBY_CYC + 12 && pwrOut.coreOff !== 1'b0; n++) @(negedge clk_sys);
            `CHECK("standby exit", 1'b0, pwrOut.coreOff)
            @(posedge clk_sys);
            stbyWake <= '0;
            extResetPin <= 1'b0;
            step(STBY_CYC + 10);
        end
        stop_test();
    end
endmodule
